// >>> sync_serial_defines.vh
`ifndef SYNC_SERIAL_DEFINES_VH
`define SYNC_SERIAL_DEFINES_VH

// bus geometry: byte address is four times the register index
`define AXI_AW        18
`define IDX_W         16

// register indices
`define IDX_PORT      16'hff91
`define IDX_MODE      16'hffa8
`define IDX_BRR       16'hffa9
`define IDX_CTRL      16'hffaa
`define IDX_TDR       16'hffab
`define IDX_STAT      16'hffac
`define IDX_IRQ_STAT  16'hffb0
`define IDX_IRQ_CLR   16'hffb1
`define IDX_IRQ_EN    16'hffb2

// decoded register codes
`define RG_PORT       4'h0
`define RG_MODE       4'h1
`define RG_BRR        4'h2
`define RG_CTRL       4'h3
`define RG_TDR        4'h4
`define RG_STAT       4'h5
`define RG_IRQ_STAT   4'h6
`define RG_IRQ_CLR    4'h7
`define RG_IRQ_EN     4'h8
`define RG_NONE       4'hf

// field positions
`define PC_SEL        5
`define PC_INV        3
`define SM_SYNC       7
`define SM_MP         2
`define SM_CKS_HI     1
`define SM_CKS_LO     0
`define SC_TE         5
`define SC_CKE_HI     1
`define SC_CKE_LO     0
`define SS_TX_HOLDING_EMPTY       7
`define SS_TX_ALL_DONE       2
`define IRQ_EMPTY     0
`define IRQ_DONE      1
`define IRQ_W         2

// reset values
`define RST_BYTE      8'h00
`define RST_IRQ       2'h0

// bit timing: half a serial clock is 4*(n+1) prescaled clocks,
// prescaler 4^cks, so n=4 and cks=0 at 10 MHz gives 4 us per bit
`define CNT_W         17
`define HALF_SHIFT    2
`define LAST_BIT      3'h7

// bus answers
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10

`endif

// >>> sync_serial_transmitter.v
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "sync_serial_defines.vh"

// Function
// - pin-select bit 5 routes shared pin: 0 general port, 1 serial out
// - invert bit 3 inverts serial output data, 0 leaves it as is
// - mode bit 7: 0 asynchronous, 1 clocked synchronous
// - clock-select bits 00 run the generator from undivided system clock
// - divisor 4 on undivided clock gives 250 kbit/s
// - tx enable bit 5: 0 blocks all transmit, 1 allows it
// - clock-enable 00 in synchronous mode: internal clock, clock pin output
// - holding register is 8 bits and holds the next byte
// - holding-empty reads 0 while a written byte waits
// - holding-empty reads 1 when nothing written or byte moved
// - transmit-complete 0 while sending, 1 once finished
// - bytes leave one bit at a time, least significant first
// - empty shifter takes pending byte automatically; none moved while empty flag 1
// - each bit driven from falling clock edge, held to next rising edge
// - software may only clear holding-empty and error flags; writing 1 sets nothing
module sync_serial_transmitter (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [`AXI_AW-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [`AXI_AW-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              gp_out_data,
  input  wire              gp_out_en,
  output reg               serial_out_pin_o,
  output reg               serial_out_pin_oe,
  output reg               serial_clock_pin_o,
  output reg               serial_clock_pin_oe,
  output reg               irq
);

  localparam ST_IDLE  = 1'b0;
  localparam ST_SHIFT = 1'b1;

  reg [7:0]         port_control_reg;
  reg [7:0]         serial_mode_reg;
  reg [7:0]         bit_rate_reg;
  reg [7:0]         serial_control_reg;
  reg [7:0]         tx_holding_reg;
  reg               tx_holding_empty;
  reg               tx_all_done;
  reg [`IRQ_W-1:0]  irq_status_reg;
  reg [`IRQ_W-1:0]  irq_enable_reg;
  reg [`AXI_AW-1:0] wr_addr_reg;
  reg [31:0]        wr_data_reg;
  reg [3:0]         wr_strb_reg;
  reg               state_reg;
  reg [7:0]         tx_shift_reg;
  reg [2:0]         bit_cnt_reg;
  reg [`CNT_W-1:0]  half_cnt_reg;
  reg               sck_reg;
  reg               txd_reg;

  // register index decode, shared by write and read paths
  function [3:0] decode;
    input [`AXI_AW-1:0] addr;
    begin
      case (addr[`AXI_AW-1:2])
        `IDX_PORT:     decode = `RG_PORT;
        `IDX_MODE:     decode = `RG_MODE;
        `IDX_BRR:      decode = `RG_BRR;
        `IDX_CTRL:     decode = `RG_CTRL;
        `IDX_TDR:      decode = `RG_TDR;
        `IDX_STAT:     decode = `RG_STAT;
        `IDX_IRQ_STAT: decode = `RG_IRQ_STAT;
        `IDX_IRQ_CLR:  decode = `RG_IRQ_CLR;
        `IDX_IRQ_EN:   decode = `RG_IRQ_EN;
        default:       decode = `RG_NONE;
      endcase
    end
  endfunction

  wire [3:0]        wr_sel       = decode(wr_addr_reg);
  wire [3:0]        rd_sel       = decode(s_axi_araddr);
  // both address and data held and no answer pending
  wire              do_wr        = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire              wr_lane      = do_wr & wr_strb_reg[0];

  // asynchronous mode is not carried; it simply never transmits
  wire              sync_mode    = serial_mode_reg[`SM_SYNC];
  wire              internal_clk = ~serial_control_reg[`SC_CKE_HI] &
                                   ~serial_control_reg[`SC_CKE_LO];
  wire              can_tx       = serial_control_reg[`SC_TE] & sync_mode &
                                   internal_clk;

  // prescaler 4^cks; cks 0 uses the undivided clock
  wire [1:0]        cks          = {serial_mode_reg[`SM_CKS_HI],
                                    serial_mode_reg[`SM_CKS_LO]};
  wire [`CNT_W-1:0] half_len     = (({{(`CNT_W-8){1'b0}}, bit_rate_reg} +
                                    {{(`CNT_W-1){1'b0}}, 1'b1}) << `HALF_SHIFT)
                                   << {cks, 1'b0};

  wire              half_end     = (half_cnt_reg == {`CNT_W{1'b0}});
  wire              frame_end    = (state_reg == ST_SHIFT) & half_end & sck_reg &
                                   (bit_cnt_reg == `LAST_BIT);
  wire              load         = can_tx & ~tx_holding_empty &
                                   ((state_reg == ST_IDLE) | frame_end);
  wire              done         = can_tx & frame_end & tx_holding_empty;

  // write address and data, each taken on its own handshake, either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      wr_addr_reg   <= {`AXI_AW{1'b0}};
      wr_data_reg   <= 32'h00000000;
      wr_strb_reg   <= 4'h0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wr_addr_reg   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wr_data_reg  <= s_axi_wdata;
        wr_strb_reg  <= s_axi_wstrb;
      end
    end
  end

  // write response
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == `RG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // configuration registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      port_control_reg   <= `RST_BYTE;
      serial_mode_reg    <= `RST_BYTE;
      bit_rate_reg       <= `RST_BYTE;
      serial_control_reg <= `RST_BYTE;
      tx_holding_reg     <= `RST_BYTE;
      irq_enable_reg     <= `RST_IRQ;
    end else if (wr_lane) begin
      case (wr_sel)
        `RG_PORT:   port_control_reg   <= wr_data_reg[7:0];
        `RG_MODE:   serial_mode_reg    <= wr_data_reg[7:0];
        `RG_BRR:    bit_rate_reg       <= wr_data_reg[7:0];
        `RG_CTRL:   serial_control_reg <= wr_data_reg[7:0];
        `RG_TDR:    tx_holding_reg     <= wr_data_reg[7:0];
        `RG_IRQ_EN: irq_enable_reg     <= wr_data_reg[`IRQ_W-1:0];
        default:    irq_enable_reg     <= irq_enable_reg;
      endcase
    end
  end

  // holding-empty: set by the move or a disabled transmitter,
  // cleared by a holding write or a written 0; set wins the tie
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_holding_empty <= 1'b1;
    end else if (load || !serial_control_reg[`SC_TE]) begin
      tx_holding_empty <= 1'b1;
    end else if (wr_lane && (wr_sel == `RG_TDR)) begin
      tx_holding_empty <= 1'b0;
    end else if (wr_lane && (wr_sel == `RG_STAT) &&
                 !wr_data_reg[`SS_TX_HOLDING_EMPTY]) begin
      tx_holding_empty <= 1'b0;
    end
  end

  // transmit complete is read-only to software
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_all_done <= 1'b1;
    end else if (done || !serial_control_reg[`SC_TE]) begin
      tx_all_done <= 1'b1;
    end else if (load) begin
      tx_all_done <= 1'b0;
    end
  end

  // interrupt status, write-one-to-clear, set wins
  genvar gi;
  generate
    for (gi = 0; gi < `IRQ_W; gi = gi + 1) begin : g_irq
      wire ev;
      assign ev = (gi == `IRQ_EMPTY) ? load : done;
      always @(posedge aclk) begin
        if (!aresetn) begin
          irq_status_reg[gi] <= 1'b0;
        end else if (ev) begin
          irq_status_reg[gi] <= 1'b1;
        end else if (wr_lane && (wr_sel == `RG_IRQ_CLR) &&
                     wr_data_reg[gi]) begin
          irq_status_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // read channel, answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      case (rd_sel)
        `RG_PORT:     s_axi_rdata[7:0] <= port_control_reg;
        `RG_MODE:     s_axi_rdata[7:0] <= serial_mode_reg;
        `RG_BRR:      s_axi_rdata[7:0] <= bit_rate_reg;
        `RG_CTRL:     s_axi_rdata[7:0] <= serial_control_reg;
        `RG_TDR:      s_axi_rdata[7:0] <= tx_holding_reg;
        `RG_STAT: begin
          // error flags stay 0: reception is not carried
          s_axi_rdata[`SS_TX_HOLDING_EMPTY] <= tx_holding_empty;
          s_axi_rdata[`SS_TX_ALL_DONE] <= tx_all_done;
        end
        `RG_IRQ_STAT: s_axi_rdata[`IRQ_W-1:0] <= irq_status_reg;
        `RG_IRQ_CLR:  s_axi_rdata[`IRQ_W-1:0] <= `RST_IRQ;
        `RG_IRQ_EN:   s_axi_rdata[`IRQ_W-1:0] <= irq_enable_reg;
        default:      s_axi_rresp <= `RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // shifter: clock idles high, bit changes with each falling edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg    <= ST_IDLE;
      tx_shift_reg <= `RST_BYTE;
      bit_cnt_reg  <= 3'h0;
      half_cnt_reg <= {`CNT_W{1'b0}};
      sck_reg      <= 1'b1;
      txd_reg      <= 1'b1;
    end else if (!can_tx) begin
      // aborts a frame under way
      state_reg <= ST_IDLE;
      sck_reg   <= 1'b1;
      txd_reg   <= 1'b1;
    end else if (load) begin
      state_reg    <= ST_SHIFT;
      tx_shift_reg <= tx_holding_reg;
      txd_reg      <= tx_holding_reg[0];
      sck_reg      <= 1'b0;
      bit_cnt_reg  <= 3'h0;
      half_cnt_reg <= half_len - {{(`CNT_W-1){1'b0}}, 1'b1};
    end else begin
      case (state_reg)
        ST_IDLE:  sck_reg <= 1'b1;
        ST_SHIFT: begin
          if (!half_end) begin
            half_cnt_reg <= half_cnt_reg - {{(`CNT_W-1){1'b0}}, 1'b1};
          end else if (!sck_reg) begin
            // rising edge: data stays put for the receiver to latch
            sck_reg      <= 1'b1;
            half_cnt_reg <= half_len - {{(`CNT_W-1){1'b0}}, 1'b1};
          end else if (bit_cnt_reg == `LAST_BIT) begin
            state_reg <= ST_IDLE;
          end else begin
            bit_cnt_reg  <= bit_cnt_reg + 3'h1;
            tx_shift_reg <= tx_shift_reg >> 1;
            txd_reg      <= tx_shift_reg[1];
            sck_reg      <= 1'b0;
            half_cnt_reg <= half_len - {{(`CNT_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // pins, one register stage so clock and data stay aligned
  always @(posedge aclk) begin
    if (!aresetn) begin
      serial_out_pin_o    <= 1'b0;
      serial_out_pin_oe   <= 1'b0;
      serial_clock_pin_o  <= 1'b1;
      serial_clock_pin_oe <= 1'b0;
    end else begin
      if (port_control_reg[`PC_SEL]) begin
        serial_out_pin_o  <= txd_reg ^ port_control_reg[`PC_INV];
        serial_out_pin_oe <= 1'b1;
      end else begin
        serial_out_pin_o  <= gp_out_data;
        serial_out_pin_oe <= gp_out_en;
      end
      serial_clock_pin_o  <= sck_reg;
      serial_clock_pin_oe <= sync_mode & internal_clk;
    end
  end

endmodule
`default_nettype wire

// >>> sync_serial_props.sv
`timescale 1ns/100ps
`default_nettype none
module sync_serial_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        serial_out_pin_o,
  input wire logic        serial_clock_pin_o,
  input wire logic        serial_clock_pin_oe
);
  // divisor 4, undivided clock: 20 cycles per half bit
  localparam int HALF = 20;
  logic [7:0] low_cnt;
  logic [7:0] high_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt  <= 8'h00;
      high_cnt <= 8'h00;
    end else begin
      low_cnt  <= serial_clock_pin_o ? 8'h00 : low_cnt + 8'h01;
      // saturates so a long idle never wraps
      high_cnt <= !serial_clock_pin_o ? 8'h00 : high_cnt + {7'h00, ~&high_cnt};
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  data_hold_a: assert property (
    $rose(serial_clock_pin_o) |-> $stable(serial_out_pin_o) [*8])
    else $error("data moved while serial clock high");
  low_half_a: assert property (
    $rose(serial_clock_pin_o) |-> low_cnt == HALF)
    else $error("serial clock low half wrong");
  high_half_a: assert property (
    $fell(serial_clock_pin_o) |-> high_cnt >= HALF)
    else $error("serial clock high half short");
  clock_drive_a: assert property (
    $fell(serial_clock_pin_o) |-> serial_clock_pin_oe)
    else $error("serial clock toggles undriven");
  write_answer_a: assert property (
    wr_taken |=> (!s_axi_awready && !s_axi_bvalid) ##1 s_axi_bvalid)
    else $error("write answer late");
  read_answer_a: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  b_stand_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  r_stand_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
endmodule
bind sync_serial_transmitter sync_serial_props u_props (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .serial_out_pin_o(serial_out_pin_o), .serial_clock_pin_o(serial_clock_pin_o),
  .serial_clock_pin_oe(serial_clock_pin_oe)
);
`default_nettype wire

// >>> sync_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
module sync_rx_model (
  input wire logic sck,
  input wire logic sd,
  input wire logic sd_oe
);
  logic [7:0] shift_reg;
  int         bit_cnt = 0;
  logic [7:0] got_q[$];
  // latch on the rise: data has settled since the fall before it
  always @(posedge sck) begin
    if (sd_oe === 1'b1) begin
      shift_reg = {sd, shift_reg[7:1]};
      bit_cnt = bit_cnt + 1;
      if (bit_cnt == 8) begin
        got_q.push_back(shift_reg);
        bit_cnt = 0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> sync_serial_transmitter_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "sync_serial_defines.vh"
module sync_serial_transmitter_test;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [`AXI_AW-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic gp_d = 0, gp_en = 0;
  logic awready, wready, bvalid, arready, rvalid, so, so_oe, sc, sc_oe, irq;
  logic [1:0] bresp, rresp;
  logic [1:0] last_bresp = 2'b00;
  logic [31:0] rdata;
  logic [7:0] exp_q[$];
  int n_fail = 0, samples_checked = 0, cycles = 0;
  always #50 aclk = ~aclk;
  sync_serial_transmitter dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .gp_out_data(gp_d), .gp_out_en(gp_en), .serial_out_pin_o(so),
    .serial_out_pin_oe(so_oe), .serial_clock_pin_o(sc), .serial_clock_pin_oe(sc_oe),
    .irq(irq));
  sync_rx_model rx (.sck(sc), .sd(so), .sd_oe(so_oe));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic aw_p, w_p;
    aw_p = 1;
    w_p = 1;
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wvalid <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (aw_p && awready === 1'b1) begin
        aw_p = 0;
        awvalid <= 1'b0;
      end
      if (w_p && wready === 1'b1) begin
        w_p = 0;
        wvalid <= 1'b0;
      end
    end
    // a late ready now and then keeps the answer standing
    if ($urandom_range(1)) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    last_bresp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] idx, output logic [7:0] d, output logic [1:0] r);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    if ($urandom_range(1)) @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_stat(input int pos);
    logic [7:0] d;
    logic [1:0] r;
    do rd(`IDX_STAT, d, r); while (d[pos] !== 1'b1);
  endtask
  task automatic send(input logic [7:0] b, input logic inv);
    wr(`IDX_TDR, b);
    exp_q.push_back(inv ? ~b : b);
  endtask
  initial begin
    logic [7:0] d, b;
    logic [1:0] r;
    void'($urandom(32'hbea5));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`IDX_STAT, d, r);
    check("status flags at reset", {d[7], d[2]}, 2'b11);
    rd(16'h0000, d, r);
    check("unmapped response", {r, d}, {`RESP_SLVERR, 8'h00});
    wr(16'h0000, 8'h00);
    check("unmapped write response", last_bresp, `RESP_SLVERR);
    gp_en <= 1'b1;
    gp_d <= $urandom_range(1);
    repeat (3) @(posedge aclk);
    check("general port pin", {so_oe, so}, {1'b1, gp_d});
    check("clock pin undriven async", sc_oe, 1'b0);
    $display("test reset done");
    wr(`IDX_MODE, 8'h80);
    wr(`IDX_BRR, 8'h04);
    wr(`IDX_PORT, 8'h20);
    wr(`IDX_CTRL, 8'h01);
    repeat (3) @(posedge aclk);
    check("clock pin outside source", sc_oe, 1'b0);
    wr(`IDX_CTRL, 8'h00);
    check("write response", last_bresp, `RESP_OKAY);
    wr(`IDX_TDR, 8'h3c);
    repeat (200) @(posedge aclk);
    check("clock pin driven high", {sc_oe, sc}, 2'b11);
    check("serial idle level", {so_oe, so}, 2'b11);
    check("bytes while disabled", rx.got_q.size(), 0);
    $display("test disabled done");
    wr(`IDX_CTRL, 8'h20);
    for (int i = 0; i < 6; i++) begin
      b = (i < 4) ? 8'(i * 8'h55) : 8'($urandom);
      send(b, 1'b0);
      if (i > 0) begin
        if (i == 2) wr(`IDX_STAT, 8'hff);
        rd(`IDX_STAT, d, r);
        check("flags with byte waiting", {d[7], d[2]}, 2'b00);
      end
      wait_stat(7);
    end
    rd(`IDX_TDR, d, r);
    check("holding readback", d, b);
    wait_stat(2);
    rd(`IDX_IRQ_STAT, d, r);
    check("completion event masked", {d[1], irq}, 2'b10);
    wr(`IDX_IRQ_EN, 8'h02);
    repeat (3) @(posedge aclk);
    check("irq raised", irq, 1'b1);
    wr(`IDX_IRQ_CLR, 8'h02);
    repeat (3) @(posedge aclk);
    check("irq cleared", irq, 1'b0);
    $display("test stream done");
    // clearing the empty flag by hand resends the held byte
    wr(`IDX_STAT, 8'h7f);
    exp_q.push_back(b);
    wait_stat(2);
    wr(`IDX_PORT, 8'h28);
    repeat (3) @(posedge aclk);
    check("inverted idle level", so, 1'b0);
    send(8'($urandom), 1'b1);
    wait_stat(2);
    repeat (4) @(posedge aclk);
    check("bytes received", rx.got_q.size(), exp_q.size());
    foreach (exp_q[k]) check("received byte", rx.got_q[k], exp_q[k]);
    $display("test resend and invert done");
    stop_test();
  end
endmodule
`default_nettype wire
